// ### inc/clk_switch_pkg.sv
package clk_switch_pkg;

  // Register indices as printed; the APB byte address is four times the index.
  localparam logic [7:0] CLOCK_SOURCE_SELECT_REG_IDX = 8'h85;
  localparam logic [7:0] OSCILLATOR_CONTROL_REG_IDX = 8'h86;
  localparam logic [7:0] CLOCK_CONTROL_REG0_IDX = 8'h8F;
  localparam logic [7:0] SWITCH_STATUS_REG_IDX = 8'h90;
  localparam int APB_ADDR_W = 12;

  // Field positions.
  localparam int CKS_BIT = 0;
  localparam int PRI_EN_BIT = 0;
  localparam int SEC_EN_BIT = 1;
  localparam int SUBCLK_T0_BIT = 2;
  localparam int NO_DIV_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_IDLE_BIT = 2;
  localparam int STAT_PDOWN_BIT = 3;

  // Reset values of control bits that do not come from a fuse.
  localparam logic SUBCLK_T0_RST = 1'b0;

  // Timing counts, in edges of the oscillator concerned.
  localparam int SWITCH_EDGES = 2;
  localparam int SUBCLK_DIV = 128;
  localparam int SUBCLK_HALF = SUBCLK_DIV / 2;
  localparam int SUBCLK_CNT_W = 6;

  // Source codes: the select bit is 1 for the primary oscillator.
  localparam logic SRC_SECONDARY = 1'b0;
  localparam logic SRC_PRIMARY = 1'b1;

  typedef struct packed {
    logic subclock_timer0_source;
    logic secondary_osc_enable;
    logic primary_osc_enable;
  } osc_ctrl_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } osc_sample_t;

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_DROP_OLD = 2'b01,
    SW_TAKE_NEW = 2'b10
  } switch_state_t;

endpackage : clk_switch_pkg

// ### core/osc_sampler.sv
// Samples an asynchronous clock or pin into the system clock domain.
module osc_sampler (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic async_i, // Asynchronous input.
  output clk_switch_pkg::osc_sample_t smp_o // Filtered level and edges.
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // The first stage only feeds the second, to keep metastability contained.
  always_ff @(posedge clk_i) begin
    s1_q <= async_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  always_comb begin
    smp_o.level = level_q;
    smp_o.rise = (s2_q == s3_q) && s3_q && !level_q;
    smp_o.fall = (s2_q == s3_q) && !s3_q && level_q;
  end

endmodule : osc_sampler

// ### core/dual_oscillator_clock_switch.sv
// Functional notes
// - Select 0 picks secondary, 1 picks primary.
// - Reset loads enables and select from fuse.
// - Active oscillator enable cannot be cleared.
// - Select toward disabled oscillator is ignored.
// - Switch completes within two periods each; in divide mode the old source can take three.
// - Exactly one source drives system clock.
// - Enabled oscillators keep running in idle.
// - No source change during idle or power-down; only the start of a switch is blocked, one already under way still completes.
// - Power-down stops all oscillators.
// - Interrupt exit keeps enables and select.
// - Reset ends low power, restores fuse defaults.
// - Timer 0 input: pin or secondary/128.
// - Secondary disabled frees its two pins.
// - Divide by two unless no-divide set.
// - No-divide resets to inverted fuse bit.
// - Both sources share the divide stage.
// - External secondary clock disables amplifier B.
module dual_oscillator_clock_switch (
  input wire logic SYS_CLK_I, // 50 MHz system clock.
  input wire logic SYS_RST_I, // Synchronous reset, active high.
  input wire logic PSEL_I, // APB select.
  input wire logic PENABLE_I, // APB enable.
  input wire logic PWRITE_I, // APB direction, high for write.
  input wire logic [clk_switch_pkg::APB_ADDR_W-1:0] PADDR_I, // APB byte address.
  input wire logic [31:0] PWDATA_I, // APB write data.
  input wire logic [3:0] PSTRB_I, // APB byte strobes.
  output logic [31:0] PRDATA_O, // APB read data.
  output logic PREADY_O, // APB ready.
  output logic PSLVERR_O, // APB error for unmapped address.
  input wire logic OSC_SEL_FUSE_I, // Oscillator select fuse, static.
  input wire logic NO_DIV_FUSE_I, // Divide fuse, static, inverted sense.
  input wire logic SEC_EXT_CLK_I, // Secondary configured as external clock.
  input wire logic IDLE_I, // Idle mode active.
  input wire logic PDOWN_I, // Power-down mode active.
  input wire logic PRI_OSC_I, // Primary oscillator output.
  input wire logic SEC_OSC_I, // Secondary oscillator output.
  input wire logic TIMER0_COUNT_PIN_I, // Timer 0 count pin.
  output logic PRI_OSC_EN_O, // Primary oscillator run enable.
  output logic SEC_OSC_EN_O, // Secondary oscillator run enable.
  output logic SEC_AMP_EN_O, // Amplifier B enable.
  output logic SEC_CLK_IN_FREE_O, // Secondary input pin free as port bit.
  output logic SEC_CLK_OUT_FREE_O, // Secondary output pin free as port bit.
  output logic SYS_CLK_O, // Generated system clock level.
  output logic TIMER0_COUNT_O, // Timer 0 counter input.
  output logic ACTIVE_SRC_O // Source now driving the system clock.
);

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling.

  logic [2:0] raw_in;
  clk_switch_pkg::osc_sample_t smp [3];

  assign raw_in = {TIMER0_COUNT_PIN_I, SEC_OSC_I, PRI_OSC_I};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_smp
      osc_sampler u_smp (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .async_i(raw_in[g]),
        .smp_o(smp[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control state.

  logic cks_q;
  logic no_div_q;
  clk_switch_pkg::osc_ctrl_t ctrl_q;
  logic active_q;
  clk_switch_pkg::switch_state_t state_q;
  logic [1:0] edge_cnt_q;
  logic sys_clk_q;
  logic low_power;

  // Interrupt exit leaves all control bits untouched; only reset restores them.
  // State held across low power.
  assign low_power = IDLE_I | PDOWN_I;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  logic setup_ok;
  logic access;
  logic wr_en;
  logic [7:0] idx;
  logic mapped;
  logic [31:0] rd_mux;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  assign idx = PADDR_I[9:2];
  assign access = PSEL_I & PENABLE_I;
  assign setup_ok = access & !pready_q;
  assign wr_en = access & pready_q & PWRITE_I & !pslverr_q & PSTRB_I[0];

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (idx)
      clk_switch_pkg::CLOCK_SOURCE_SELECT_REG_IDX: begin
        rd_mux[clk_switch_pkg::CKS_BIT] = cks_q;
      end
      clk_switch_pkg::OSCILLATOR_CONTROL_REG_IDX: begin
        rd_mux[clk_switch_pkg::PRI_EN_BIT] = ctrl_q.primary_osc_enable;
        rd_mux[clk_switch_pkg::SEC_EN_BIT] = ctrl_q.secondary_osc_enable;
        rd_mux[clk_switch_pkg::SUBCLK_T0_BIT] = ctrl_q.subclock_timer0_source;
      end
      clk_switch_pkg::CLOCK_CONTROL_REG0_IDX: begin
        rd_mux[clk_switch_pkg::NO_DIV_BIT] = no_div_q;
      end
      clk_switch_pkg::SWITCH_STATUS_REG_IDX: begin
        rd_mux[clk_switch_pkg::STAT_ACTIVE_BIT] = active_q;
        rd_mux[clk_switch_pkg::STAT_BUSY_BIT] = (state_q != clk_switch_pkg::SW_RUN);
        rd_mux[clk_switch_pkg::STAT_IDLE_BIT] = IDLE_I;
        rd_mux[clk_switch_pkg::STAT_PDOWN_BIT] = PDOWN_I;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (PADDR_I[clk_switch_pkg::APB_ADDR_W-1:10] != '0 || PADDR_I[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // One wait state: ready rises in the second access cycle.
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_ok;
      pslverr_q <= setup_ok & !mapped;
      if (setup_ok && !PWRITE_I && mapped) begin
        prdata_q <= rd_mux;
      end else if (setup_ok) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible control bits.

  logic sel_target;
  logic target_enabled;

  assign sel_target = PWDATA_I[clk_switch_pkg::CKS_BIT];
  assign target_enabled = sel_target ? ctrl_q.primary_osc_enable : ctrl_q.secondary_osc_enable;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      cks_q <= OSC_SEL_FUSE_I;
    end else if (wr_en && idx == clk_switch_pkg::CLOCK_SOURCE_SELECT_REG_IDX) begin
      if (target_enabled) begin
        cks_q <= sel_target;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q.primary_osc_enable <= OSC_SEL_FUSE_I;
      ctrl_q.secondary_osc_enable <= !OSC_SEL_FUSE_I;
      ctrl_q.subclock_timer0_source <= clk_switch_pkg::SUBCLK_T0_RST;
    end else if (wr_en && idx == clk_switch_pkg::OSCILLATOR_CONTROL_REG_IDX) begin
      // Keep active enable set.
      // The source still driving during a switch is protected as well.
      ctrl_q.primary_osc_enable <= PWDATA_I[clk_switch_pkg::PRI_EN_BIT]
        | (cks_q == clk_switch_pkg::SRC_PRIMARY) | (active_q == clk_switch_pkg::SRC_PRIMARY);
      ctrl_q.secondary_osc_enable <= PWDATA_I[clk_switch_pkg::SEC_EN_BIT]
        | (cks_q == clk_switch_pkg::SRC_SECONDARY) | (active_q == clk_switch_pkg::SRC_SECONDARY);
      ctrl_q.subclock_timer0_source <= PWDATA_I[clk_switch_pkg::SUBCLK_T0_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      no_div_q <= !NO_DIV_FUSE_I;
    end else if (wr_en && idx == clk_switch_pkg::CLOCK_CONTROL_REG0_IDX) begin
      no_div_q <= PWDATA_I[clk_switch_pkg::NO_DIV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator enables and pin release.

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      PRI_OSC_EN_O <= 1'b0;
      SEC_OSC_EN_O <= 1'b0;
    end else begin
      PRI_OSC_EN_O <= ctrl_q.primary_osc_enable & !PDOWN_I;
      SEC_OSC_EN_O <= ctrl_q.secondary_osc_enable & !PDOWN_I;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      SEC_AMP_EN_O <= 1'b0;
      SEC_CLK_IN_FREE_O <= 1'b0;
      SEC_CLK_OUT_FREE_O <= 1'b0;
    end else begin
      SEC_AMP_EN_O <= ctrl_q.secondary_osc_enable & !SEC_EXT_CLK_I & !PDOWN_I;
      SEC_CLK_IN_FREE_O <= !ctrl_q.secondary_osc_enable;
      SEC_CLK_OUT_FREE_O <= !ctrl_q.secondary_osc_enable | SEC_EXT_CLK_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source switch.

  clk_switch_pkg::osc_sample_t old_src;
  clk_switch_pkg::osc_sample_t new_src;
  logic div_low_next;

  assign old_src = (active_q == clk_switch_pkg::SRC_PRIMARY) ? smp[0] : smp[1];
  assign new_src = (cks_q == clk_switch_pkg::SRC_PRIMARY) ? smp[0] : smp[1];
  // In divide mode the output only goes low when the divider is already low.
  assign div_low_next = no_div_q | !sys_clk_q;

  // The old source is released at one of its falling edges with the output
  // low, and the new one is taken only at its second rising edge. This costs
  // a few dead periods but never produces a short pulse.
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      state_q <= clk_switch_pkg::SW_RUN;
      edge_cnt_q <= 2'd0;
      // Active source from fuse.
      // Starting on the fuse source avoids waiting on an oscillator that reset has stopped.
      active_q <= OSC_SEL_FUSE_I;
    end else begin
      case (state_q)
        clk_switch_pkg::SW_RUN: begin
          edge_cnt_q <= 2'd0;
          if (edge_cnt_q == 2'd0 && active_q != cks_q && !low_power) begin
            state_q <= clk_switch_pkg::SW_DROP_OLD;
          end
        end
        clk_switch_pkg::SW_DROP_OLD: begin
          if (old_src.fall) begin
            if (edge_cnt_q != 2'd0 && div_low_next) begin
              state_q <= clk_switch_pkg::SW_TAKE_NEW;
              edge_cnt_q <= 2'd0;
            end else begin
              edge_cnt_q <= 2'd1;
            end
          end
        end
        clk_switch_pkg::SW_TAKE_NEW: begin
          if (new_src.rise) begin
            if (edge_cnt_q == 2'(clk_switch_pkg::SWITCH_EDGES - 1)) begin
              state_q <= clk_switch_pkg::SW_RUN;
              active_q <= cks_q;
              edge_cnt_q <= 2'd0;
            end else begin
              edge_cnt_q <= edge_cnt_q + 2'd1;
            end
          end
        end
        default: begin
          state_q <= clk_switch_pkg::SW_RUN;
          edge_cnt_q <= 2'd0;
        end
      endcase
    end
  end

  // Fuse default applies to the active source through a one-cycle catch-up.
  logic fuse_loaded_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      fuse_loaded_q <= 1'b0;
    end else begin
      fuse_loaded_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divide-by-two stage and system clock.

  logic take_edge;

  // Completing a switch is done on a rising edge of the new source.
  assign take_edge = state_q == clk_switch_pkg::SW_TAKE_NEW && new_src.rise
    && edge_cnt_q == 2'(clk_switch_pkg::SWITCH_EDGES - 1);

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sys_clk_q <= 1'b0;
    end else if (!fuse_loaded_q) begin
      sys_clk_q <= 1'b0;
    end else if (state_q == clk_switch_pkg::SW_TAKE_NEW) begin
      sys_clk_q <= take_edge;
    end else if (no_div_q) begin
      sys_clk_q <= old_src.level;
    end else if (old_src.rise) begin
      sys_clk_q <= !sys_clk_q;
    end
  end

  assign SYS_CLK_O = sys_clk_q;

  // The active source follows the fuse straight out of reset.
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ACTIVE_SRC_O <= 1'b0;
    end else begin
      ACTIVE_SRC_O <= fuse_loaded_q ? active_q : cks_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer 0 count source.

  logic [clk_switch_pkg::SUBCLK_CNT_W-1:0] sub_cnt_q;
  logic sub_clk_q;

  // Rising edges of the secondary are counted, so the subclock stops with it.
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sub_cnt_q <= '0;
      sub_clk_q <= 1'b0;
    end else if (smp[1].rise) begin
      if (sub_cnt_q == clk_switch_pkg::SUBCLK_CNT_W'(clk_switch_pkg::SUBCLK_HALF - 1)) begin
        sub_cnt_q <= '0;
        sub_clk_q <= !sub_clk_q;
      end else begin
        sub_cnt_q <= sub_cnt_q + clk_switch_pkg::SUBCLK_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      TIMER0_COUNT_O <= 1'b0;
    end else begin
      TIMER0_COUNT_O <= ctrl_q.subclock_timer0_source ? sub_clk_q : smp[2].level;
    end
  end

endmodule : dual_oscillator_clock_switch

// ### dv/dual_oscillator_clock_switch_chk.sv
module clk_switch_chk (
  input wire logic SYS_CLK_I, // Clock.
  input wire logic SYS_RST_I, // Reset.
  input wire logic IDLE_I, // Idle mode.
  input wire logic PDOWN_I, // Power-down mode.
  input wire logic SEC_EXT_CLK_I, // External secondary.
  input wire logic PRI_OSC_EN_O, // Primary run.
  input wire logic SEC_OSC_EN_O, // Secondary run.
  input wire logic SEC_AMP_EN_O, // Amplifier B.
  input wire logic SEC_CLK_IN_FREE_O, // Input pin free.
  input wire logic SEC_CLK_OUT_FREE_O, // Output pin free.
  input wire logic SYS_CLK_O, // System clock.
  input wire logic ACTIVE_SRC_O // Active source.
);
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  logic low_pwr;
  assign low_pwr = IDLE_I || PDOWN_I;
  ////////////////////////////////////////
  pdown_gate_a: assert property (PDOWN_I |=> !PRI_OSC_EN_O && !SEC_OSC_EN_O)
    else $error("oscillator enabled in power-down");
  // Outputs are only trusted from the second edge after reset.
  pri_hold_a: assert property (ACTIVE_SRC_O && !$past(PDOWN_I) && !$past(SYS_RST_I) |-> PRI_OSC_EN_O)
    else $error("active primary stopped");
  sec_hold_a: assert property (!ACTIVE_SRC_O && !$past(PDOWN_I) && !$past(SYS_RST_I) |-> SEC_OSC_EN_O)
    else $error("active secondary stopped");
  lp_freeze_a: assert property (low_pwr && $past(low_pwr) |-> $stable(ACTIVE_SRC_O))
    else $error("source changed in low power");
  runt_high_a: assert property ($rose(SYS_CLK_O) |-> SYS_CLK_O [*3])
    else $error("short high pulse");
  runt_low_a: assert property ($fell(SYS_CLK_O) |-> !SYS_CLK_O [*3])
    else $error("short low pulse");
  amp_ext_a: assert property (SEC_EXT_CLK_I |=> !SEC_AMP_EN_O)
    else $error("amplifier on with external clock");
  pin_free_a: assert property (SEC_OSC_EN_O |-> !SEC_CLK_IN_FREE_O)
    else $error("input pin freed while running");
  out_free_a: assert property (SEC_CLK_IN_FREE_O |-> SEC_CLK_OUT_FREE_O)
    else $error("output pin kept");
  cover property ($fell(ACTIVE_SRC_O));
  cover property ($rose(ACTIVE_SRC_O));
  cover property (IDLE_I && PRI_OSC_EN_O && SEC_OSC_EN_O);
endmodule : clk_switch_chk

bind dual_oscillator_clock_switch clk_switch_chk i_chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
  .IDLE_I(IDLE_I), .PDOWN_I(PDOWN_I), .SEC_EXT_CLK_I(SEC_EXT_CLK_I), .PRI_OSC_EN_O(PRI_OSC_EN_O),
  .SEC_OSC_EN_O(SEC_OSC_EN_O), .SEC_AMP_EN_O(SEC_AMP_EN_O), .SEC_CLK_IN_FREE_O(SEC_CLK_IN_FREE_O),
  .SEC_CLK_OUT_FREE_O(SEC_CLK_OUT_FREE_O), .SYS_CLK_O(SYS_CLK_O), .ACTIVE_SRC_O(ACTIVE_SRC_O));

// ### dv/osc_pair.sv
module osc_pair #(
  parameter int PRI_HALF_NS = 100,
  parameter int SEC_HALF_NS = 160
) (
  input wire logic pri_en_i, // Primary run enable.
  input wire logic sec_en_i, // Secondary run enable.
  output logic pri_o, // Primary output.
  output logic sec_o // Secondary output.
);
  timeunit 1ns;
  timeprecision 1ps;
  // run only enabled
  // A stopped oscillator rests low; it gives no ready flag, so software must wait.
  initial begin
    pri_o = 1'h0;
    forever begin
      if (pri_en_i === 1'h1) begin
        #(PRI_HALF_NS) pri_o = 1'h1;
        #(PRI_HALF_NS) pri_o = 1'h0;
      end else begin
        @(pri_en_i);
      end
    end
  end
  initial begin
    sec_o = 1'h0;
    forever begin
      if (sec_en_i === 1'h1) begin
        #(SEC_HALF_NS) sec_o = 1'h1;
        #(SEC_HALF_NS) sec_o = 1'h0;
      end else begin
        @(sec_en_i);
      end
    end
  end
endmodule : osc_pair

// ### dv/test_dual_oscillator_clock_switch.sv
module test_dual_oscillator_clock_switch;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TP = 10;
  localparam int TS = 16;
  localparam logic [7:0] R_SEL = clk_switch_pkg::CLOCK_SOURCE_SELECT_REG_IDX;
  localparam logic [7:0] R_OSC = clk_switch_pkg::OSCILLATOR_CONTROL_REG_IDX;
  localparam logic [7:0] R_DIV = clk_switch_pkg::CLOCK_CONTROL_REG0_IDX;
  localparam logic [7:0] R_STAT = clk_switch_pkg::SWITCH_STATUS_REG_IDX;
  logic clk, rst, psel, penable, pwrite, fuse, x2f, ext, idle, pdown, pin, pready, pslverr, rerr;
  logic pri_osc, sec_osc, pri_en, sec_en, amp_en, in_free, out_free, sclk, t0, act;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  int err_total, n_tests, hi, per;
  dual_oscillator_clock_switch i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .OSC_SEL_FUSE_I(fuse), .NO_DIV_FUSE_I(x2f),
    .SEC_EXT_CLK_I(ext), .IDLE_I(idle), .PDOWN_I(pdown), .PRI_OSC_I(pri_osc), .SEC_OSC_I(sec_osc),
    .TIMER0_COUNT_PIN_I(pin), .PRI_OSC_EN_O(pri_en), .SEC_OSC_EN_O(sec_en), .SEC_AMP_EN_O(amp_en),
    .SEC_CLK_IN_FREE_O(in_free), .SEC_CLK_OUT_FREE_O(out_free), .SYS_CLK_O(sclk),
    .TIMER0_COUNT_O(t0), .ACTIVE_SRC_O(act));
  osc_pair #(.PRI_HALF_NS(TP * 10), .SEC_HALF_NS(TS * 10)) i_osc (.pri_en_i(pri_en), .sec_en_i(sec_en),
    .pri_o(pri_osc), .sec_o(sec_osc));
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask : chkb
  // Sampling jitter of the oscillator inputs allows one cycle either way.
  task automatic near(input int got, input int exp, input string what);
    chkb(1'(got <= exp + 1 && got >= exp - 1), 1'h1, what);
  endtask : near
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chkb(1'(n < 16), 1'h1, "ready");
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'h0, idx, 32'h0);
    chk(rdat, exp, what);
  endtask : rd
  task automatic wait_lvl(input logic t, input logic v, output int k);
    k = 0;
    while ((t ? t0 : sclk) !== v && k < 2200) begin
      @(posedge clk);
      k++;
    end
  endtask : wait_lvl
  task automatic meas(input logic t);
    int k;
    wait_lvl(t, 1'h1, k);
    wait_lvl(t, 1'h0, k);
    wait_lvl(t, 1'h1, k);
    wait_lvl(t, 1'h0, hi);
    wait_lvl(t, 1'h1, k);
    per = hi + k;
  endtask : meas
  task automatic wait_act(input logic v, input int lim);
    int n;
    n = 0;
    while (act !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chkb(act, v, "active source");
  endtask : wait_act
  ////////////////////////////////////////
  task automatic t_reset(input logic f, input logic xf);
    fuse <= f;
    x2f <= xf;
    idle <= 1'h0;
    pdown <= 1'h0;
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    rd(R_OSC, {30'h0, ~f, f}, "osc control");
    rd(R_SEL, {31'h0, f}, "select");
    rd(R_DIV, {31'h0, ~xf}, "no divide");
    chkb(act, f, "source");
    chkb(in_free, f, "pin free");
  endtask : t_reset
  task automatic t_guard();
    apb(1'h1, R_SEL, 32'h0);
    rd(R_SEL, 32'h1, "select to stopped");
    apb(1'h1, R_OSC, 32'h0);
    rd(R_OSC, 32'h1, "clear active");
    apb(1'h0, 8'h84, 32'h0);
    chkb(rerr, 1'h1, "unmapped");
  endtask : t_guard
  task automatic t_switch();
    meas(1'h0);
    near(per, 2 * TP, "half rate period");
    near(hi, TP, "half rate duty");
    apb(1'h1, R_OSC, 32'h3);
    // Settling wait in place of a stability flag, which the hardware lacks.
    repeat (40) @(posedge clk);
    apb(1'h1, R_SEL, 32'h0);
    wait_act(1'h0, 3 * TP + 2 * TS + 8);
    // Unused primary stopped to save power.
    apb(1'h1, R_OSC, 32'h2);
    rd(R_OSC, 32'h2, "drop old");
    rd(R_STAT, 32'h0, "status");
    meas(1'h0);
    near(per, 2 * TS, "secondary divided");
  endtask : t_switch
  task automatic t_timer();
    pin <= 1'h1;
    // Subclock used only with the secondary running as crystal.
    apb(1'h1, R_OSC, 32'h6);
    meas(1'h1);
    near(per, 128 * TS, "subclock period");
    near(hi, 64 * TS, "subclock duty");
    apb(1'h1, R_OSC, 32'h2);
    repeat (8) @(posedge clk);
    chkb(t0, 1'h1, "pin high");
    pin <= 1'h0;
    repeat (8) @(posedge clk);
    chkb(t0, 1'h0, "pin low");
  endtask : t_timer
  task automatic t_lowpower();
    apb(1'h1, R_OSC, 32'h3);
    repeat (40) @(posedge clk);
    idle <= 1'h1;
    apb(1'h1, R_SEL, 32'h1);
    repeat (100) @(posedge clk);
    chkb(act, 1'h0, "held in idle");
    chkb(pri_en & sec_en, 1'h1, "idle runs");
    idle <= 1'h0;
    wait_act(1'h1, 3 * TS + 2 * TP + 12);
    pdown <= 1'h1;
    apb(1'h1, R_DIV, 32'h1);
    chkb(pri_en | sec_en, 1'h0, "all stopped");
    rd(R_DIV, 32'h1, "no divide set");
    pdown <= 1'h0;
    rd(R_OSC, 32'h3, "kept enables");
    rd(R_SEL, 32'h1, "kept select");
    meas(1'h0);
    near(per, TP, "full rate");
  endtask : t_lowpower
  task automatic t_ext();
    ext <= 1'h1;
    t_reset(1'h0, 1'h0);
    chkb(amp_en, 1'h0, "amplifier off");
    chkb(out_free, 1'h1, "output pin free");
  endtask : t_ext
  ////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    err_total = 0;
    n_tests = 0;
    {rst, psel, penable, pwrite, fuse, x2f, ext, idle, pdown, pin} = 10'h200;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    @(posedge clk);
    t_reset(1'h1, 1'h1);
    t_guard();
    t_switch();
    t_timer();
    t_lowpower();
    t_ext();
    wrap_up();
  end
endmodule : test_dual_oscillator_clock_switch
